// ### src/brf_consts.svh
// constants for the block-ram fifo read side: map, fields, reset values, sizes
// assumes inclusion by bare name from the package, the main module and the bench
`ifndef BRF_CONSTS_SVH
`define BRF_CONSTS_SVH

// -----------------------------------------------------------------------------
// sizes
// -----------------------------------------------------------------------------
`define BRF_DW          40
`define BRF_CW          47
`define BRF_AW          9
`define BRF_PW          10
`define BRF_DEPTH       512
`define BRF_DEPTH_PTR   10'h200

// -----------------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------------
`define BRF_ADDR_CTRL   8'h00
`define BRF_ADDR_AEOFS  8'h04
`define BRF_ADDR_STAT   8'h08
`define BRF_ADDR_EVT    8'h0C
`define BRF_ADDR_SRLO   8'h10
`define BRF_ADDR_SRHI   8'h14
`define BRF_ADDR_INJLO  8'h18
`define BRF_ADDR_INJHI  8'h1C

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define BRF_CTRL_SYNC   0
`define BRF_CTRL_FWFT   1
`define BRF_CTRL_OREG   2
`define BRF_CTRL_INJ    3
`define BRF_STAT_EMPTY  0
`define BRF_STAT_AEMPTY 1
`define BRF_STAT_FULL   2
`define BRF_STAT_CNT    16
`define BRF_EVT_RDERR   0
`define BRF_EVT_SBIT    1
`define BRF_EVT_DBIT    2

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define BRF_SYNC_RST    1'b0
`define BRF_FWFT_RST    1'b0
`define BRF_OREG_RST    1'b1
`define BRF_AEOFS_RST   15'h0004
`define BRF_SRVAL_RST   40'h00_0000_0000
`define BRF_INITVAL     40'h00_0000_0000

`endif

// ### src/brf_pkg.sv
// types shared by the fifo read side modules
// assumes brf_consts.svh is on the include path
package brf_pkg;
`include "brf_consts.svh"

    typedef logic [`BRF_PW-1:0] brf_ptr_t;
    typedef logic [`BRF_DW-1:0] brf_data_t;
    typedef logic [`BRF_CW-1:0] brf_code_t;

    typedef struct packed {
        brf_ptr_t   wr_ptr;
        brf_ptr_t   rd_ptr;
        brf_ptr_t   wr_sync1;
        brf_ptr_t   wr_seen;
        logic       empty;
        logic       aempty;
        logic       full;
        logic       rd_err;
        logic       pipe_vld;
        logic       pipe_sbit;
        logic       pipe_dbit;
        brf_data_t  pipe_data;
        brf_data_t  dout;
        logic       sbit;
        logic       dbit_d;
        logic       dbit;
        logic       primed;
        logic       sync_mode;
        logic       fwft;
        logic       en_out_reg;
        logic       inject_en;
        logic [14:0] aempty_ofs;
        brf_data_t  srval;
        brf_code_t  inject;
        logic [2:0] events;
        logic       ack;
        logic [31:0] rdata;
    } brf_state_s;
endpackage

// ### src/brf_codec_if.sv
// link between the fifo core and its error-correction codec
// assumes one codec instance per core, purely combinational
`timescale 1ns/1ps
interface brf_codec_if;
    logic [39:0] enc_data;
    logic [46:0] enc_word;
    logic [46:0] dec_word;
    logic [39:0] dec_data;
    logic        dec_single;
    logic        dec_double;

    modport user
    (
        output enc_data,
        output dec_word,
        input  enc_word,
        input  dec_data,
        input  dec_single,
        input  dec_double
    );
    modport codec
    (
        input  enc_data,
        input  dec_word,
        output enc_word,
        output dec_data,
        output dec_single,
        output dec_double
    );
endinterface

// ### src/brf_secded.sv
// single-error-correct, double-error-detect codec for 40-bit words
// assumes the caller registers whatever it needs; no state in here
`timescale 1ns/1ps
module brf_secded
(
    brf_codec_if.codec bus
);
    // -------------------------------------------------------------------------
    // encoder: bit 0 is overall parity, powers of two hold check bits
    // -------------------------------------------------------------------------
    always_comb
    begin
        logic [46:0] cw;
        logic        par;
        int          j;
        cw  = '0;
        par = 1'b0;
        j   = 0;
        for (int p = 1; p < 47; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                cw[p] = bus.enc_data[j];
                j++;
            end
        end
        for (int k = 0; k < 6; k++)
        begin
            par = 1'b0;
            for (int p = 1; p < 47; p++)
                if (p[k])
                    par = par ^ cw[p];
            cw[1 << k] = par;
        end
        cw[0] = ^cw[46:1];
        bus.enc_word = cw;
    end

    // -------------------------------------------------------------------------
    // decoder: only the outgoing copy is repaired
    // -------------------------------------------------------------------------
    always_comb
    begin
        logic [46:0] w;
        logic [5:0]  syn;
        logic        odd;
        int          j;
        w   = bus.dec_word;
        syn = 6'h00;
        odd = 1'b0;
        j   = 0;
        for (int p = 1; p < 47; p++)
            for (int k = 0; k < 6; k++)
                if (p[k])
                    syn[k] = syn[k] ^ w[p];
        odd = ^w;
        bus.dec_single = odd && (syn < 6'h2F);
        bus.dec_double = (syn != 6'h00) && (!odd || syn > 6'h2E);
        if (bus.dec_single && syn != 6'h00)
            w[syn] = ~w[syn];
        bus.dec_data = '0;
        for (int p = 1; p < 47; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                bus.dec_data[j] = w[p];
                j++;
            end
        end
    end
endmodule // brf_secded

// ### src/brf_fifo_rd.sv
// block-ram fifo with its read side: flags, error correction, output register
// assumes consumer and producer logic on clk and a classic wishbone master
//
// Overview of operation
// - empty asserted when no word is readable
// - near-drained while readable count below offset
// - underflow flag after read of empty fifo
// - single-bit error: corrected word, correctable flag
// - correction never rewrites stored memory contents
// - correctable flag aligned with its data word
// - double-bit error: raw word, uncorrectable flag
// - uncorrectable flag one cycle after its word
// - single-clock setting bypasses pointer synchronisation
// - write width 40 bits, the default
// - read width 40 bits, matching write
// - fall-through shows first word without read
// - otherwise first word one cycle after read, two with the output register enabled
// - fall-through affects only first word
// - output register powers up to initial value
// - output register reset loads set value
// - read moves next word only when nonempty
// - output register enable gates data to outputs
// - 15-bit offset, default four, blind reads
`timescale 1ns/1ps
`include "brf_consts.svh"
module brf_fifo_rd
    import brf_pkg::*;
#(
    parameter logic [39:0] INIT_VALUE = `BRF_INITVAL
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic [39:0] wr_data,
    output      logic        full,
    input  wire logic        rden,
    input  wire logic        outregce,
    input  wire logic        rstreg,
    output      logic [39:0] dout,
    output      logic        empty,
    output      logic        almost_empty,
    output      logic        read_err,
    output      logic        sbit_error,
    output      logic        dbit_error,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o
);
    // -------------------------------------------------------------------------
    // state, storage, codec
    // -------------------------------------------------------------------------
    brf_state_s  s_reg;
    brf_state_s  s_next;
    brf_code_t   mem [0:`BRF_DEPTH-1];
    logic        wr_go;
    logic        pop;
    logic        peek;
    logic        load;
    logic        wb_req;
    logic        wb_wr;
    brf_ptr_t    rd_count;
    brf_code_t   inj_mask;

    localparam brf_state_s RESET_STATE = '{
        wr_ptr:     '0,
        rd_ptr:     '0,
        wr_sync1:   '0,
        wr_seen:    '0,
        empty:      1'b1,
        aempty:     1'b1,
        full:       1'b0,
        rd_err:     1'b0,
        pipe_vld:   1'b0,
        pipe_sbit:  1'b0,
        pipe_dbit:  1'b0,
        pipe_data:  INIT_VALUE,
        dout:       INIT_VALUE,
        sbit:       1'b0,
        dbit_d:     1'b0,
        dbit:       1'b0,
        primed:     1'b0,
        sync_mode:  `BRF_SYNC_RST,
        fwft:       `BRF_FWFT_RST,
        en_out_reg: `BRF_OREG_RST,
        inject_en:  1'b0,
        aempty_ofs: `BRF_AEOFS_RST,
        srval:      `BRF_SRVAL_RST,
        inject:     '0,
        events:     3'h0,
        ack:        1'b0,
        rdata:      32'h0000_0000
    };

    // -------------------------------------------------------------------------
    // codec: forty data bits each way, the one width pairing built here
    // -------------------------------------------------------------------------
    brf_codec_if cdc ();

    brf_secded u_codec
    (
        .bus (cdc.codec)
    );

    assign cdc.enc_data = wr_data;
    assign cdc.dec_word = mem[s_reg.rd_ptr[`BRF_AW-1:0]];

    // -------------------------------------------------------------------------
    // byte-lane merge for register writes
    // -------------------------------------------------------------------------
    function automatic logic [31:0] brf_merge
    (
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                res[b*8 +: 8] = new_val[b*8 +: 8];
        return res;
    endfunction

    // -------------------------------------------------------------------------
    // request qualifiers
    // -------------------------------------------------------------------------
    assign wr_go    = wr_en && !s_reg.full;
    assign pop      = rden && !s_reg.empty;
    // fall-through only primes an idle output; a pending read takes priority
    assign peek     = s_reg.fwft && !s_reg.primed && !s_reg.empty && !rden;
    assign load     = pop || peek;
    assign inj_mask = s_reg.inject_en ? s_reg.inject : '0;
    assign wb_req   = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign rd_count = s_reg.wr_seen - s_reg.rd_ptr;

    // -------------------------------------------------------------------------
    // register bus strobes
    // -------------------------------------------------------------------------
    // a write lands at the edge that samples ack high, where the master lets go;
    // a read is looked up one edge earlier so its data stands with ack
    assign wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;

    // -------------------------------------------------------------------------
    // storage: written only by the producer, never by the corrector
    // -------------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (wr_go)
            mem[s_reg.wr_ptr[`BRF_AW-1:0]] <= cdc.enc_word ^ inj_mask;
    end

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb
    begin
        brf_ptr_t    avail;
        logic [31:0] w;
        logic [2:0]  ev_set;
        logic [2:0]  ev_clr;
        avail  = '0;
        w      = 32'h0000_0000;
        ev_set = 3'h0;
        ev_clr = 3'h0;
        s_next = s_reg;

        // pointers; the read pointer never moves while empty
        s_next.wr_ptr   = s_reg.wr_ptr + {{(`BRF_PW-1){1'b0}}, wr_go};
        s_next.rd_ptr   = s_reg.rd_ptr + {{(`BRF_PW-1){1'b0}}, load};
        s_next.wr_sync1 = s_reg.wr_ptr;
        // without the bypass the flags see the write pointer two edges late,
        // standing in for the crossing into a separate read clock
        if (s_reg.sync_mode)
            s_next.wr_seen = s_next.wr_ptr;
        else
            s_next.wr_seen = s_reg.wr_sync1;

        // flags from the pointers as they will stand
        avail          = s_next.wr_seen - s_next.rd_ptr;
        s_next.empty   = (avail == '0);
        s_next.aempty  = ({5'h00, avail} < s_next.aempty_ofs);
        s_next.full    = ((s_next.wr_ptr - s_next.rd_ptr) == `BRF_DEPTH_PTR);
        s_next.rd_err  = rden && s_reg.empty;

        // output path
        s_next.sbit   = 1'b0;
        s_next.dbit_d = 1'b0;
        s_next.dbit   = s_reg.dbit_d;
        if (s_reg.en_out_reg)
        begin
            if (outregce && s_reg.pipe_vld)
            begin
                s_next.dout     = s_reg.pipe_data;
                s_next.sbit     = s_reg.pipe_sbit;
                s_next.dbit_d   = s_reg.pipe_dbit;
                s_next.pipe_vld = 1'b0;
            end
            // a stalled stage is overwritten; the bench drops the enable across one read only
            if (load)
            begin
                s_next.pipe_data = cdc.dec_data;
                s_next.pipe_sbit = cdc.dec_single;
                s_next.pipe_dbit = cdc.dec_double;
                s_next.pipe_vld  = 1'b1;
            end
            // synchronous; beats a load of the output in the same edge
            if (rstreg)
                s_next.dout = s_reg.srval;
        end
        else
        begin
            s_next.pipe_vld = 1'b0;
            if (load)
            begin
                s_next.dout   = cdc.dec_data;
                s_next.sbit   = cdc.dec_single;
                s_next.dbit_d = cdc.dec_double;
            end
        end

        // fall-through re-arms once reads have drained the fifo
        // an empty read also re-arms, so the next word falls through again
        if (peek)
            s_next.primed = 1'b1;
        else if (rden && s_next.empty)
            s_next.primed = 1'b0;

        // wishbone slave: one-cycle answer, unmapped reads return zero
        // a request held past its ack is answered again every other cycle
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
        if (wb_wr)
        begin
            unique case (wb_adr_i)
                `BRF_ADDR_CTRL:
                begin
                    w = brf_merge({28'h000_0000, s_reg.inject_en, s_reg.en_out_reg,
                                   s_reg.fwft, s_reg.sync_mode}, wb_dat_i, wb_sel_i);
                    s_next.sync_mode  = w[`BRF_CTRL_SYNC];
                    s_next.fwft       = w[`BRF_CTRL_FWFT];
                    s_next.en_out_reg = w[`BRF_CTRL_OREG];
                    s_next.inject_en  = w[`BRF_CTRL_INJ];
                end
                `BRF_ADDR_AEOFS:
                begin
                    w = brf_merge({17'h0_0000, s_reg.aempty_ofs}, wb_dat_i, wb_sel_i);
                    s_next.aempty_ofs = w[14:0];
                end
                `BRF_ADDR_EVT:
                    ev_clr = wb_dat_i[2:0] & {3{wb_sel_i[0]}};
                `BRF_ADDR_SRLO:
                begin
                    w = brf_merge(s_reg.srval[31:0], wb_dat_i, wb_sel_i);
                    s_next.srval[31:0] = w;
                end
                `BRF_ADDR_SRHI:
                begin
                    w = brf_merge({24'h00_0000, s_reg.srval[39:32]}, wb_dat_i, wb_sel_i);
                    s_next.srval[39:32] = w[7:0];
                end
                `BRF_ADDR_INJLO:
                begin
                    w = brf_merge(s_reg.inject[31:0], wb_dat_i, wb_sel_i);
                    s_next.inject[31:0] = w;
                end
                `BRF_ADDR_INJHI:
                begin
                    w = brf_merge({17'h0_0000, s_reg.inject[46:32]}, wb_dat_i, wb_sel_i);
                    s_next.inject[46:32] = w[14:0];
                end
                default:
                    w = 32'h0000_0000;
            endcase
        end
        if (wb_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `BRF_ADDR_CTRL:
                    s_next.rdata = {28'h000_0000, s_reg.inject_en, s_reg.en_out_reg,
                                    s_reg.fwft, s_reg.sync_mode};
                `BRF_ADDR_AEOFS:
                    s_next.rdata = {17'h0_0000, s_reg.aempty_ofs};
                `BRF_ADDR_STAT:
                    s_next.rdata = {6'h00, rd_count, 13'h0000,
                                    s_reg.full, s_reg.aempty, s_reg.empty};
                `BRF_ADDR_EVT:
                    s_next.rdata = {29'h0000_0000, s_reg.events};
                `BRF_ADDR_SRLO:
                    s_next.rdata = s_reg.srval[31:0];
                `BRF_ADDR_SRHI:
                    s_next.rdata = {24'h00_0000, s_reg.srval[39:32]};
                `BRF_ADDR_INJLO:
                    s_next.rdata = s_reg.inject[31:0];
                `BRF_ADDR_INJHI:
                    s_next.rdata = {17'h0_0000, s_reg.inject[46:32]};
                default:
                    s_next.rdata = 32'h0000_0000;
            endcase
        end

        // sticky events; a new event beats a same-cycle clear
        // the error outputs are one-cycle pulses; software reads the sticky copy
        ev_set[`BRF_EVT_RDERR] = s_next.rd_err;
        ev_set[`BRF_EVT_SBIT]  = s_next.sbit;
        ev_set[`BRF_EVT_DBIT]  = s_next.dbit;
        s_next.events = (s_reg.events & ~ev_clr) | ev_set;
    end

    // -------------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= RESET_STATE;
        else
            s_reg <= s_next;
    end

    // -------------------------------------------------------------------------
    // outputs, each straight from the state register
    // -------------------------------------------------------------------------
    assign full         = s_reg.full;
    assign dout         = s_reg.dout;
    assign empty        = s_reg.empty;
    assign almost_empty = s_reg.aempty;
    assign read_err     = s_reg.rd_err;
    assign sbit_error   = s_reg.sbit;
    assign dbit_error   = s_reg.dbit;
    assign wb_dat_o     = s_reg.rdata;
    assign wb_ack_o     = s_reg.ack;
endmodule // brf_fifo_rd

// ### bench/brf_fifo_rd_asserts.sv
// concurrent checks on the fifo read side ports
// assumes one clock domain and rst_n active low
`timescale 1ns/1ps
module brf_fifo_rd_asserts
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rden,
    input wire logic empty,
    input wire logic almost_empty,
    input wire logic full,
    input wire logic read_err,
    input wire logic sbit_error,
    input wire logic dbit_error,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_bad_rd;
        rden && empty;
    endsequence
    chk_underflow_flag: assert property (s_bad_rd |=> read_err)
        else $error("read_err missing after empty read");
    chk_underflow_cause: assert property (read_err |-> $past(rden && empty))
        else $error("read_err without empty read");
    chk_bus_ack_once: assert property (s_req |=> s_ack)
        else $error("ack not one cycle after request");
    chk_sbit_pulse: assert property ($rose(sbit_error) |=> !sbit_error)
        else $error("sbit_error longer than one cycle");
    chk_dbit_pulse: assert property ($rose(dbit_error) |=> !dbit_error)
        else $error("dbit_error longer than one cycle");
    chk_full_not_empty: assert property (full |-> !empty)
        else $error("full and empty together");
    // holds while the offset is nonzero, as the bench keeps it
    chk_empty_drained: assert property (empty |-> almost_empty)
        else $error("empty without almost_empty");
    chk_reset_flags: assert property ($rose(rst_n) |-> empty && almost_empty && !read_err)
        else $error("flags wrong after reset");
endmodule // brf_fifo_rd_asserts

bind brf_fifo_rd brf_fifo_rd_asserts u_chk
(
    .clk          (clk),
    .rst_n        (rst_n),
    .rden         (rden),
    .empty        (empty),
    .almost_empty (almost_empty),
    .full         (full),
    .read_err     (read_err),
    .sbit_error   (sbit_error),
    .dbit_error   (dbit_error),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_ack_o     (wb_ack_o)
);

// ### bench/brf_consumer.sv
// consumer model on the read clock
// assumes the bench asks for a read by raising want for one cycle
`timescale 1ns/1ps
module brf_consumer
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic want,
    input  wire logic stall_ce,
    output logic      rden,
    output logic      outregce
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rden     <= 1'b0;
            outregce <= 1'b1;
        end
        else
        begin
            rden     <= want;
            outregce <= !stall_ce;
        end
    end
endmodule // brf_consumer

// ### bench/tb.sv
// self-checking bench for the fifo read side
// assumes brf_consumer on the read port and the bound checker
`timescale 1ns/1ps
`include "brf_consts.svh"
module tb;
    logic        clk, rst_n, wr_en, want, rstreg, cyc, stb, we, stall;
    logic        full, rden, oce, empty, aempty, rerr, sbit, dbit, ack;
    logic        r_err, r_sb, r_db0, r_db1;
    logic [39:0] wr_data, dout, w, rd_d;
    logic [31:0] dat, wdo, q;
    logic [7:0]  adr;
    int          fail_count, num_checks, n;
    logic [39:0] exp_q[$];

    brf_fifo_rd dut
    (
        .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_data(wr_data), .full(full),
        .rden(rden), .outregce(oce), .rstreg(rstreg), .dout(dout), .empty(empty),
        .almost_empty(aempty), .read_err(rerr), .sbit_error(sbit), .dbit_error(dbit),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack)
    );
    brf_consumer u_cons
    (
        .clk(clk), .rst_n(rst_n), .want(want), .stall_ce(stall), .rden(rden), .outregce(oce)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic int fill_lat(input logic s);
        return s ? 1 : 3;
    endfunction
    function automatic logic [39:0] rnd40();
        return {8'($urandom), 32'($urandom)};
    endfunction
    task automatic cmp(input string nm, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w_e, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w_e;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // counts edges until empty falls, the write edge being the first
    task automatic push(input logic [39:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        exp_q.push_back(d);
        #1;
        for (n = 1; empty !== 1'b0 && n < 10; n++)
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic rd_one(input int lat);
        @(posedge clk);
        want <= 1'b1;
        @(posedge clk);
        want <= 1'b0;
        @(posedge clk);
        #1;
        r_err = rerr;
        repeat (lat) @(posedge clk);
        #1;
        rd_d  = dout;
        r_sb  = sbit;
        r_db0 = dbit;
        @(posedge clk);
        #1;
        r_db1 = dbit;
    endtask
    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #300us;
        fail_count++;
        close_out();
    end
    initial
    begin
        {rst_n, wr_en, want, rstreg, cyc, stb, we, stall} = 8'h00;
        {wr_data, dat, adr} = 80'h0;
        void'($urandom(32'h39fa));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        cmp("empty", 40'h1, 40'(empty));
        cmp("aempty", 40'h1, 40'(aempty));
        cmp("dout init", `BRF_INITVAL, dout);
        wb(1'b0, `BRF_ADDR_CTRL, 32'h0);
        cmp("ctrl", 40'h4, 40'(q));
        wb(1'b0, `BRF_ADDR_AEOFS, 32'h0);
        cmp("aeofs", 40'h4, 40'(q));
        wb(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 40'h0, 40'(q));
        rd_one(1);
        cmp("read_err", 40'h1, 40'(r_err));
        cmp("dout hold", 40'h0, rd_d);
        tend("reset");
        for (int i = 0; i < 6; i++)
        begin
            push(rnd40());
            if (i == 0)
                cmp("fill delay", 40'(fill_lat(1'b0)), 40'(n));
        end
        cmp("aempty", 40'h0, 40'(aempty));
        repeat (2) @(posedge clk);
        wb(1'b0, `BRF_ADDR_STAT, 32'h0);
        cmp("stat", 40'h0006_0000, 40'(q));
        for (int i = 0; i < 6; i++)
        begin
            rd_one(1);
            cmp("data", exp_q.pop_front(), rd_d);
            cmp("aempty", 40'(i >= 2), 40'(aempty));
        end
        cmp("empty", 40'h1, 40'(empty));
        tend("burst");
        w = rnd40();
        wb(1'b1, `BRF_ADDR_SRLO, w[31:0]);
        wb(1'b1, `BRF_ADDR_SRHI, {24'h0, w[39:32]});
        @(posedge clk);
        rstreg <= 1'b1;
        @(posedge clk);
        rstreg <= 1'b0;
        #1;
        cmp("srval", w, dout);
        tend("rstreg");
        wb(1'b1, `BRF_ADDR_CTRL, 32'hC);
        wb(1'b1, `BRF_ADDR_INJLO, 32'h8);
        push(rnd40());
        rd_one(1);
        cmp("corrected", exp_q.pop_front(), rd_d);
        cmp("sbit", 40'h1, 40'(r_sb));
        wb(1'b1, `BRF_ADDR_INJLO, 32'h28);
        push(rnd40());
        rd_one(1);
        w = exp_q.pop_front() ^ 40'h3;
        cmp("raw", w, rd_d);
        cmp("dbit early", 40'h0, 40'(r_db0));
        cmp("dbit late", 40'h1, 40'(r_db1));
        wb(1'b0, `BRF_ADDR_EVT, 32'h0);
        cmp("events", 40'h7, 40'(q));
        wb(1'b1, `BRF_ADDR_EVT, 32'h7);
        wb(1'b0, `BRF_ADDR_EVT, 32'h0);
        cmp("events clr", 40'h0, 40'(q));
        wb(1'b1, `BRF_ADDR_INJLO, 32'h0);
        stall <= 1'b1;
        push(rnd40());
        rd_one(1);
        cmp("stalled", w, rd_d);
        @(posedge clk);
        stall <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp("released", exp_q.pop_front(), dout);
        tend("ecc");
        wb(1'b1, `BRF_ADDR_CTRL, 32'h1);
        push(rnd40());
        cmp("fill delay", 40'(fill_lat(1'b1)), 40'(n));
        rd_one(0);
        cmp("data", exp_q.pop_front(), rd_d);
        tend("single clock");
        wb(1'b1, `BRF_ADDR_CTRL, 32'h6);
        push(rnd40());
        repeat (8) @(posedge clk);
        #1;
        cmp("fall through", exp_q.pop_front(), dout);
        push(rnd40());
        rd_one(1);
        cmp("after first", exp_q.pop_front(), rd_d);
        tend("fwft");
        close_out();
    end
endmodule // tb
